// >>> core/regstat_defs.svh
`ifndef REGSTAT_DEFS_SVH
`define REGSTAT_DEFS_SVH

`define ADDR_STATUS        8'h05
`define ADDR_IRQ_MASK      8'h06
`define ADDR_IRQ_LATCH     8'h07
`define MASK_RESET_VAL     8'hFF
`define STATUS_RESET_VAL   8'h00
`define BIT_POWER_GOOD     7
`define BIT_UNDERVOLT      6
`define BIT_OVERVOLT       5
`define BIT_RISING         4
`define BIT_FALLING        3
`define BIT_SOFT_RESET     2
`define BIT_THERMAL        1
`define BIT_ENABLED        0
`define NUM_SOURCES        5

`endif

// >>> core/regstat_pkg.sv
package regstat_pkg;
    typedef struct packed {
        logic power_good;
        logic input_undervolt;
        logic input_overvolt;
        logic rising_slew;
        logic falling_slew;
        logic thermal_shutdown;
        logic converter_enabled;
    } analog_flags_s;

    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef enum logic [1:0] {
        IRQ_IDLE   = 2'b01,
        IRQ_ACTIVE = 2'b10
    } irq_state_e;
endpackage

// >>> core/sticky_bit.sv
`timescale 1ns/1ns
`default_nettype none
module sticky_bit (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic set_pulse,
    input  wire logic clr_pulse,
    output var  logic bit_q
);
    logic bit_next;

    // Set wins over a coincident clear
    assign bit_next = set_pulse | (bit_q & ~clr_pulse);

    always_ff @(posedge mclk) begin
        if (srst) begin
            bit_q <= 1'b0;
        end else begin
            bit_q <= bit_next;
        end
    end
endmodule // sticky_bit
`default_nettype wire

// >>> core/regulator_status_irq_mask.sv
`timescale 1ns/1ns
`default_nettype none
`include "regstat_defs.svh"
module regulator_status_irq_mask
    import regstat_pkg::*;
#(
    parameter int NSRC = `NUM_SOURCES
) (
    input  wire logic          mclk,
    input  wire logic          srst,
    input  wire reg_req_s      req,
    input  wire logic          soft_reset_cmd,
    input  wire analog_flags_s flags,
    output var  logic [7:0]    rdata,
    output var  logic          converter_shutdown,
    output var  logic          irq_n
);
    logic [7:0]      mask_reg;
    logic [7:0]      mask_next;
    logic            soft_flag;
    logic [7:0]      rdata_next;
    logic [NSRC-1:0] latch_q;
    logic [NSRC-1:0] latch_set;
    logic [NSRC-1:0] latch_clr;
    logic            rising_prev;
    logic            falling_prev;
    logic            thermal_prev;
    logic            enabled_prev;
    logic            rd_status;
    logic            rd_latch;
    logic            wr_mask;
    logic            rd_mask;
    logic            irq_any;
    logic            shutdown_next;
    logic [7:0]      live;
    irq_state_e      irq_state;

    assign rd_status = req.rd_en && (req.addr == `ADDR_STATUS);
    assign rd_mask   = req.rd_en && (req.addr == `ADDR_IRQ_MASK);
    assign rd_latch  = req.rd_en && (req.addr == `ADDR_IRQ_LATCH);
    assign wr_mask   = req.wr_en && (req.addr == `ADDR_IRQ_MASK);

    // Whole byte writable, reserved bits included
    assign mask_next = wr_mask ? req.wdata : mask_reg;

    // Live status byte
    assign live = {flags.power_good,
                   flags.input_undervolt,
                   flags.input_overvolt,
                   flags.rising_slew,
                   flags.falling_slew,
                   soft_flag,
                   flags.thermal_shutdown,
                   flags.converter_enabled};

    // Latch events: rising edges of slew, thermal; falling edge of enable; soft-reset command
    assign latch_set = {flags.rising_slew & ~rising_prev,
                        flags.falling_slew & ~falling_prev,
                        soft_reset_cmd,
                        flags.thermal_shutdown & ~thermal_prev,
                        ~flags.converter_enabled & enabled_prev};
    assign latch_clr = {NSRC{rd_latch}};

    assign shutdown_next = flags.input_undervolt | flags.input_overvolt;

    assign irq_any = |(latch_q & ~mask_reg[NSRC-1:0]);

    always_comb begin
        rdata_next = 8'h00;
        if (rd_status) begin
            rdata_next = live;
        end else if (rd_mask) begin
            rdata_next = mask_reg;
        end else if (rd_latch) begin
            rdata_next = {{(8-NSRC){1'b0}}, latch_q};
        end
    end

    // Software-reset status: set by command, cleared only by its read or by srst
    sticky_bit u_soft_flag (
        .mclk      (mclk),
        .srst      (srst),
        .set_pulse (soft_reset_cmd),
        .clr_pulse (rd_status),
        .bit_q     (soft_flag)
    );

    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_latch
            sticky_bit u_latch (
                .mclk      (mclk),
                .srst      (srst),
                .set_pulse (latch_set[g]),
                .clr_pulse (latch_clr[g]),
                .bit_q     (latch_q[g])
            );
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (srst) begin
            mask_reg           <= `MASK_RESET_VAL;
            rdata              <= 8'h00;
            converter_shutdown <= 1'b0;
            rising_prev        <= 1'b0;
            falling_prev       <= 1'b0;
            thermal_prev       <= 1'b0;
            enabled_prev       <= 1'b0;
        end else begin
            mask_reg           <= mask_next;
            rdata              <= rdata_next;
            converter_shutdown <= shutdown_next;
            rising_prev        <= flags.rising_slew;
            falling_prev       <= flags.falling_slew;
            thermal_prev       <= flags.thermal_shutdown;
            enabled_prev       <= flags.converter_enabled;
        end
    end

    // Interrupt output state
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_state <= IRQ_IDLE;
            irq_n     <= 1'b1;
        end else begin
            case (irq_state)
                IRQ_IDLE: begin
                    if (irq_any) begin
                        irq_state <= IRQ_ACTIVE;
                        irq_n     <= 1'b0;
                    end
                end
                IRQ_ACTIVE: begin
                    if (!irq_any) begin
                        irq_state <= IRQ_IDLE;
                        irq_n     <= 1'b1;
                    end
                end
                default: begin
                    irq_state <= IRQ_IDLE;
                    irq_n     <= 1'b1;
                end
            endcase
        end
    end

    sequence soft_cmd_s;
        soft_reset_cmd;
    endsequence

    sequence soft_seen_s;
        ##1 soft_flag;
    endsequence

    property soft_set_p;
        @(posedge mclk) disable iff (srst) soft_cmd_s |-> soft_seen_s;
    endproperty

    soft_set_a: assert property (soft_set_p)
        else $error("soft reset flag not set");

    soft_hold_a: assert property (@(posedge mclk) disable iff (srst)
        soft_flag && !rd_status |=> soft_flag)
        else $error("soft reset flag lost without read");

    soft_clear_a: assert property (@(posedge mclk) disable iff (srst)
        rd_status && !soft_reset_cmd |=> !soft_flag)
        else $error("soft reset flag not cleared by read");

    mask_write_a: assert property (@(posedge mclk) disable iff (srst)
        wr_mask |=> mask_reg == $past(req.wdata))
        else $error("mask write not stored");

    mask_reset_a: assert property (@(posedge mclk) disable iff (srst)
        $past(srst) |-> mask_reg == 8'hFF)
        else $error("mask not all ones after reset");

    status_read_a: assert property (@(posedge mclk) disable iff (srst)
        rd_status |=> rdata[7] == $past(flags.power_good) && rdata[0] == $past(flags.converter_enabled))
        else $error("status read wrong");

    flags_read_a: assert property (@(posedge mclk) disable iff (srst)
        rd_status |=> rdata[6:3] == $past({flags.input_undervolt, flags.input_overvolt,
                                           flags.rising_slew, flags.falling_slew})
                      && rdata[1] == $past(flags.thermal_shutdown))
        else $error("status flags read wrong");

    shutdown_a: assert property (@(posedge mclk) disable iff (srst)
        flags.input_undervolt || flags.input_overvolt |=> converter_shutdown)
        else $error("converter not shut off");

    latch_sticky_a: assert property (@(posedge mclk) disable iff (srst)
        latch_q[`BIT_RISING] && !rd_latch |=> latch_q[`BIT_RISING])
        else $error("rising latch lost");

    rising_latch_a: assert property (@(posedge mclk) disable iff (srst)
        flags.rising_slew && !rising_prev |=> latch_q[`BIT_RISING])
        else $error("rising latch not set");

    irq_assert_a: assert property (@(posedge mclk) disable iff (srst)
        irq_any |=> !irq_n)
        else $error("interrupt not asserted");

    irq_release_a: assert property (@(posedge mclk) disable iff (srst)
        !irq_any |=> irq_n)
        else $error("interrupt not released");
endmodule // regulator_status_irq_mask
`default_nettype wire

// >>> testbench/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model
    import regstat_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic [7:0] rdata,
    output var  reg_req_s   req
);
    initial req = '0;
    // One-cycle read strobe, data taken one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
        @(negedge mclk);
        d = rdata;
        req = '0;
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge mclk);
        req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: v};
        @(negedge mclk);
        req = '0;
    endtask
endmodule // host_model
`default_nettype wire

// >>> testbench/regulator_status_irq_mask_tb.sv
`timescale 1ns/1ns
`default_nettype none
module regulator_status_irq_mask_tb
    import regstat_pkg::*;
;
    logic          mclk           = 1'b0;
    logic          srst           = 1'b1;
    logic          soft_reset_cmd = 1'b0;
    analog_flags_s flags          = '0;
    reg_req_s      req;
    logic [7:0]    rdata;
    logic          converter_shutdown;
    logic          irq_n;
    logic [7:0]    d;
    int            fails          = 0;
    int            checks         = 0;

    always #4 mclk = ~mclk;

    regulator_status_irq_mask i_regulator_status_irq_mask (
        .mclk               (mclk),
        .srst               (srst),
        .req                (req),
        .soft_reset_cmd     (soft_reset_cmd),
        .flags              (flags),
        .rdata              (rdata),
        .converter_shutdown (converter_shutdown),
        .irq_n              (irq_n)
    );

    host_model i_host_model (
        .mclk  (mclk),
        .rdata (rdata),
        .req   (req)
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Bounded wait for the interrupt line to reach a level
    task automatic wait_irq(input logic lvl);
        for (int n = 0; n < 8 && irq_n !== lvl; n++) @(negedge mclk);
        chk({7'h00, irq_n}, {7'h00, lvl});
        if (irq_n !== lvl) final_report();
    endtask

    task automatic test_reset;
        i_host_model.rd(8'h06, d);
        chk(d, 8'hFF);
        i_host_model.rd(8'h05, d);
        chk(d, 8'h00);
        i_host_model.rd(8'h07, d);
        chk(d, 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        $display("test_reset done");
    endtask

    task automatic test_status;
        logic [7:0] e;
        for (int i = 0; i < 7; i++) begin
            flags = analog_flags_s'(7'(1 << i));
            @(negedge mclk);
            e = (i >= 2) ? 8'(1 << (i + 1)) : 8'(1 << i);
            i_host_model.rd(8'h05, d);
            chk(d, e);
            chk({7'h00, converter_shutdown}, {7'h00, (i == 4 || i == 5)});
        end
        flags = '0;
        chk({7'h00, irq_n}, 8'h01);
        i_host_model.rd(8'h07, d);
        chk(d, 8'h1B);
        i_host_model.rd(8'h07, d);
        chk(d, 8'h00);
        $display("test_status done");
    endtask

    task automatic test_soft;
        @(negedge mclk);
        soft_reset_cmd = 1'b1;
        @(negedge mclk);
        soft_reset_cmd = 1'b0;
        i_host_model.rd(8'h05, d);
        chk(d, 8'h04);
        i_host_model.rd(8'h05, d);
        chk(d, 8'h00);
        i_host_model.rd(8'h07, d);
        chk(d, 8'h04);
        $display("test_soft done");
    endtask

    task automatic test_mask;
        i_host_model.wr(8'h06, 8'hEF);
        i_host_model.rd(8'h06, d);
        chk(d, 8'hEF);
        chk({7'h00, irq_n}, 8'h01);
        flags.rising_slew = 1'b1;
        wait_irq(1'b0);
        flags = '0;
        i_host_model.rd(8'h07, d);
        chk(d, 8'h10);
        wait_irq(1'b1);
        i_host_model.wr(8'h06, 8'h1F);
        i_host_model.rd(8'h06, d);
        chk(d, 8'h1F);
        $display("test_mask done");
    endtask

    // Each remaining source alone, only its own mask bit open
    task automatic test_sources;
        flags.converter_enabled = 1'b1;
        for (int k = 0; k < 4; k++) begin
            i_host_model.wr(8'h06, ~(8'h01 << k));
            case (k)
                0: flags.converter_enabled = 1'b0;
                1: flags.thermal_shutdown = 1'b1;
                2: soft_reset_cmd = 1'b1;
                default: flags.falling_slew = 1'b1;
            endcase
            @(negedge mclk);
            soft_reset_cmd = 1'b0;
            flags = '0;
            wait_irq(1'b0);
            i_host_model.rd(8'h07, d);
            chk(d, 8'h01 << k);
            wait_irq(1'b1);
        end
        i_host_model.rd(8'h05, d);
        chk(d, 8'h04);
        i_host_model.rd(8'h05, d);
        chk(d, 8'h00);
        $display("test_sources done");
    endtask

    // Reset in mid-run with pending state, then refused accesses
    task automatic test_midrst;
        i_host_model.wr(8'h06, 8'h00);
        soft_reset_cmd = 1'b1;
        @(negedge mclk);
        soft_reset_cmd = 1'b0;
        srst = 1'b1;
        repeat (2) @(negedge mclk);
        srst = 1'b0;
        chk({7'h00, irq_n}, 8'h01);
        i_host_model.wr(8'h05, 8'h00);
        i_host_model.rd(8'h06, d);
        chk(d, 8'hFF);
        i_host_model.rd(8'h08, d);
        chk(d, 8'h00);
        i_host_model.rd(8'h05, d);
        chk(d, 8'h00);
        i_host_model.rd(8'h07, d);
        chk(d, 8'h00);
        $display("test_midrst done");
    endtask

    initial begin
        repeat (16) @(negedge mclk);
        srst = 1'b0;
        test_reset();
        test_status();
        test_soft();
        test_mask();
        test_sources();
        test_midrst();
        final_report();
    end
endmodule // regulator_status_irq_mask_tb
`default_nettype wire
